// ===== logic/hall_latch_pkg.sv
// Shared types, timing figures and reset values of the hall latch sample sequencer.
package hall_latch_pkg;

	// Timing figures as printed, then derived cycle counts rounded to the nearest cycle.
	localparam real CLK_HZ           = 10.0e6;
	localparam real AWAKE_US         = 25.0;
	localparam real EXT_DELAY_US     = 25.0;
	localparam real NORM_PERIOD_MS   = 0.7;
	localparam real SLOW_PERIOD_MS   = 28.0;
	localparam int  FAST_SLEEP_AWAKES = 8;
	localparam int  TIMEOUT_SLOW_PERIODS = 100;

	localparam int AWAKE_CYC       = int'(AWAKE_US * CLK_HZ / 1.0e6);
	localparam int EXT_DELAY_CYC   = int'(EXT_DELAY_US * CLK_HZ / 1.0e6);
	localparam int FAST_SLEEP_CYC  = FAST_SLEEP_AWAKES * AWAKE_CYC;
	localparam int NORM_PERIOD_CYC = int'(NORM_PERIOD_MS * CLK_HZ / 1.0e3);
	localparam int SLOW_PERIOD_CYC = int'(SLOW_PERIOD_MS * CLK_HZ / 1.0e3);
	localparam int TIMEOUT_CYC     = TIMEOUT_SLOW_PERIODS * SLOW_PERIOD_CYC;

	localparam int TIMER_W = 32;

	// Output is high (off) after reset; the first sample beyond a threshold corrects it.
	localparam logic OUT_RESET  = 1'b1;
	localparam logic OUT_ON     = 1'b0;
	localparam logic OUT_OFF    = 1'b1;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_DUAL,
		MODE_EXT_SLEEP,
		MODE_EXT_AWAKE
	} clock_mode_t;

	typedef enum logic {
		PH_SLEEP,
		PH_AWAKE
	} phase_t;

	typedef struct packed {
		logic extClk;
		logic dualClk;
	} clock_pins_t;

	typedef struct packed {
		logic aboveOperateThreshold;
		logic belowReleaseThreshold;
	} field_sense_t;

endpackage

// ===== logic/hall_latch_sample_sequencer.sv
// Duty-cycled sampling and output latch control of a micro-power magnetic latch.
`timescale 1ns/10ps

module hall_latch_sample_sequencer #(
	parameter int NORM_PERIOD_CYC = hall_latch_pkg::NORM_PERIOD_CYC,
	parameter int SLOW_PERIOD_CYC = hall_latch_pkg::SLOW_PERIOD_CYC,
	parameter int TIMEOUT_CYC     = hall_latch_pkg::TIMEOUT_CYC
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rstn,
	input  wire hall_latch_pkg::clock_pins_t  clockPins,
	input  wire hall_latch_pkg::field_sense_t fieldSense,
	output logic                              latchedOutput,
	output logic                              circuitsAwake,
	output logic                              sampleStrobe,
	output logic                              fastSampling
);

	localparam int TW = hall_latch_pkg::TIMER_W;
	localparam logic [TW-1:0] AWAKE_LEN = TW'(hall_latch_pkg::AWAKE_CYC);
	localparam logic [TW-1:0] DELAY_LEN = TW'(hall_latch_pkg::EXT_DELAY_CYC);
	localparam logic [TW-1:0] FAST_LEN  = TW'(hall_latch_pkg::FAST_SLEEP_CYC);
	localparam logic [TW-1:0] NORM_LEN  = TW'(NORM_PERIOD_CYC - hall_latch_pkg::AWAKE_CYC);
	localparam logic [TW-1:0] SLOW_LEN  = TW'(SLOW_PERIOD_CYC - hall_latch_pkg::AWAKE_CYC);
	localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYC - 1);

	// Two-stage synchronisers for pins and comparator levels.
	logic [3:0] syncA_q;
	logic [3:0] syncB_q;
	logic       dualPrev_q;

	hall_latch_pkg::clock_mode_t mode;
	hall_latch_pkg::clock_mode_t mode_q;
	logic                        modeValid_q;
	hall_latch_pkg::phase_t      phase_q;
	hall_latch_pkg::phase_t      phase_d;
	logic                        fast_q;
	logic                        fast_d;
	logic                        out_q;
	logic                        out_d;
	logic                        sample_q;
	logic [TW-1:0]               timeout_q;

	wire extLevel   = syncB_q[3];
	wire dualLevel  = syncB_q[2];
	wire above      = syncB_q[1];
	wire below      = syncB_q[0];
	wire dualEdge   = dualLevel != dualPrev_q;
	wire modeChange = !modeValid_q || (mode != mode_q);
	wire isExt      = (mode == hall_latch_pkg::MODE_EXT_AWAKE) ||
	                  (mode == hall_latch_pkg::MODE_EXT_SLEEP);
	wire isDual     = mode == hall_latch_pkg::MODE_DUAL;
	wire isAwake    = phase_q == hall_latch_pkg::PH_AWAKE;
	wire sampleNow  = isAwake && (phase_d == hall_latch_pkg::PH_SLEEP);
	wire outChange  = sampleNow && (out_d != out_q);
	wire timeoutHit = fast_q && (timeout_q == TIMEOUT_LAST);

	logic          timerLoad;
	logic [TW-1:0] timerValue;
	logic          timerRunning;
	logic          timerExpired;
	logic [TW-1:0] sleepLen;

	// Mode decode is purely combinational, so a synchronised pin change acts at once.
	always_comb begin
		case ({extLevel, dualLevel})
			2'b00: mode = hall_latch_pkg::MODE_NORMAL;
			2'b01: mode = hall_latch_pkg::MODE_DUAL;
			2'b10: mode = hall_latch_pkg::MODE_EXT_SLEEP;
			2'b11: mode = hall_latch_pkg::MODE_EXT_AWAKE;
			default: mode = hall_latch_pkg::MODE_NORMAL;
		endcase
	end

	assign sleepLen = !isDual ? NORM_LEN : (fast_q ? FAST_LEN : SLOW_LEN);

	phase_timer #(
		.WIDTH (TW)
	) u_timer (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.load      (timerLoad),
		.loadValue (timerValue),
		.running   (timerRunning),
		.expired   (timerExpired)
	);

	always_comb begin
		phase_d    = phase_q;
		timerLoad  = 1'b0;
		timerValue = AWAKE_LEN;
		if (modeChange) begin
			timerLoad = 1'b1;
			if (isExt) begin
				timerValue = DELAY_LEN;
			end else begin
				phase_d = hall_latch_pkg::PH_AWAKE;
			end
		end else if (isExt) begin
			if (dualEdge) begin
				timerLoad  = 1'b1;
				timerValue = DELAY_LEN;
			end else if (timerExpired) begin
				phase_d = dualLevel ? hall_latch_pkg::PH_AWAKE : hall_latch_pkg::PH_SLEEP;
			end
		end else if (timerExpired) begin
			timerLoad = 1'b1;
			case (phase_q)
				hall_latch_pkg::PH_AWAKE: begin
					phase_d    = hall_latch_pkg::PH_SLEEP;
					timerValue = sleepLen;
				end
				hall_latch_pkg::PH_SLEEP: begin
					phase_d    = hall_latch_pkg::PH_AWAKE;
					timerValue = AWAKE_LEN;
				end
				default: begin
					phase_d    = hall_latch_pkg::PH_AWAKE;
					timerValue = AWAKE_LEN;
				end
			endcase
		end
	end

	// The comparator is looked at only as the awake interval ends.
	always_comb begin
		out_d = out_q;
		if (sampleNow) begin
			if (above) begin
				out_d = hall_latch_pkg::OUT_ON;
			end else if (below) begin
				out_d = hall_latch_pkg::OUT_OFF;
			end
		end
	end

	always_comb begin
		fast_d = fast_q;
		if (modeChange && isDual) begin
			fast_d = 1'b0;
		end else if (!isDual) begin
			fast_d = 1'b0;
		end else if (outChange) begin
			fast_d = 1'b1;
		end else if (timeoutHit) begin
			fast_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			syncA_q    <= 4'h0;
			syncB_q    <= 4'h0;
			dualPrev_q <= 1'b0;
		end else begin
			syncA_q    <= {clockPins, fieldSense};
			syncB_q    <= syncA_q;
			dualPrev_q <= syncB_q[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mode_q      <= hall_latch_pkg::MODE_NORMAL;
			modeValid_q <= 1'b0;
			phase_q     <= hall_latch_pkg::PH_SLEEP;
			fast_q      <= 1'b0;
			out_q       <= hall_latch_pkg::OUT_RESET;
			sample_q    <= 1'b0;
		end else begin
			mode_q      <= mode;
			modeValid_q <= 1'b1;
			phase_q     <= phase_d;
			fast_q      <= fast_d;
			out_q       <= out_d;
			sample_q    <= sampleNow;
		end
	end

	// Each output change restarts the fast-sampling timeout.
	always_ff @(posedge clk_sys) begin
		if (!rstn || !fast_q || outChange || modeChange) begin
			timeout_q <= '0;
		end else begin
			timeout_q <= timeout_q + 1'b1;
		end
	end

	assign latchedOutput = out_q;
	assign circuitsAwake = isAwake;
	assign sampleStrobe  = sample_q;
	assign fastSampling  = fast_q;

	// Helper for the checks: cycles since the last timer load.
	logic [TW-1:0] phaseLen_q;
	always_ff @(posedge clk_sys) begin
		if (!rstn || timerLoad) begin
			phaseLen_q <= '0;
		end else begin
			phaseLen_q <= phaseLen_q + 1'b1;
		end
	end

	property p_operate;
		@(posedge clk_sys) disable iff (!rstn)
		(sampleNow && above) |=> (latchedOutput == 1'b0) && sampleStrobe;
	endproperty
	a_operate: assert property (p_operate) else $error("operate sample not latched low");

	property p_release;
		@(posedge clk_sys) disable iff (!rstn)
		(sampleNow && !above && below) |=> (latchedOutput == 1'b1);
	endproperty
	a_release: assert property (p_release) else $error("release sample not latched high");

	property p_band_hold;
		@(posedge clk_sys) disable iff (!rstn)
		(sampleNow && !above && !below) |=> $stable(latchedOutput);
	endproperty
	a_band_hold: assert property (p_band_hold) else $error("output moved inside band");

	property p_sleep_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!circuitsAwake ##1 !circuitsAwake |-> $stable(latchedOutput);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("output changed while asleep");

	property p_awake_len;
		@(posedge clk_sys) disable iff (!rstn)
		(!isExt && !modeChange && isAwake && timerExpired)
			|-> (phaseLen_q == AWAKE_LEN - 1'b1) ##1 !circuitsAwake;
	endproperty
	a_awake_len: assert property (p_awake_len) else $error("awake interval length wrong");

	// Only a sleep loaded while fast_q was already set uses the fast length.
	logic sleepFast_q;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sleepFast_q <= 1'b0;
		end else if (timerLoad) begin
			sleepFast_q <= fast_q;
		end
	end

	property p_fast_sleep;
		@(posedge clk_sys) disable iff (!rstn)
		(isDual && sleepFast_q && !modeChange && !isAwake && timerExpired)
			|-> (phaseLen_q == FAST_LEN - 1'b1);
	endproperty
	a_fast_sleep: assert property (p_fast_sleep) else $error("fast sleep length wrong");

	property p_ext_awake;
		@(posedge clk_sys) disable iff (!rstn)
		(mode == hall_latch_pkg::MODE_EXT_AWAKE && !modeChange && !timerRunning)
			|-> circuitsAwake;
	endproperty
	a_ext_awake: assert property (p_ext_awake) else $error("not awake with both pins high");

	property p_ext_sleep;
		@(posedge clk_sys) disable iff (!rstn)
		(mode == hall_latch_pkg::MODE_EXT_SLEEP && !modeChange && !timerRunning)
			|-> !circuitsAwake;
	endproperty
	a_ext_sleep: assert property (p_ext_sleep) else $error("awake in external sleep");

	property p_ext_delay;
		@(posedge clk_sys) disable iff (!rstn)
		(isExt && $past(isExt) && (phase_q != $past(phase_q)))
			|-> ($past(phaseLen_q) == DELAY_LEN - 1'b1);
	endproperty
	a_ext_delay: assert property (p_ext_delay) else $error("external transition delay wrong");

	property p_dual_start;
		@(posedge clk_sys) disable iff (!rstn)
		(isDual && modeChange) |=> !fastSampling;
	endproperty
	a_dual_start: assert property (p_dual_start) else $error("dual mode did not start slow");

	property p_go_fast;
		@(posedge clk_sys) disable iff (!rstn)
		(isDual && !modeChange && outChange) |=> fastSampling;
	endproperty
	a_go_fast: assert property (p_go_fast) else $error("no fast sampling after change");

	property p_timeout;
		@(posedge clk_sys) disable iff (!rstn)
		(isDual && !modeChange && !outChange && timeoutHit) |=> !fastSampling;
	endproperty
	a_timeout: assert property (p_timeout) else $error("fast sampling did not time out");

endmodule

// ===== logic/phase_timer.sv
// Down-counting interval timer that flags the last cycle of a loaded interval.
`timescale 1ns/10ps
module phase_timer #(
	parameter int WIDTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	output logic                  running,
	output logic                  expired
);

	logic [WIDTH-1:0] count_q;
	logic             running_q;

	assign running = running_q;
	assign expired = running_q && (count_q == '0);

	// A load of N makes expired rise in the N-th cycle after the loading edge.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count_q   <= '0;
			running_q <= 1'b0;
		end else if (load) begin
			count_q   <= loadValue - 1'b1;
			running_q <= 1'b1;
		end else if (expired) begin
			running_q <= 1'b0;
		end else if (running_q) begin
			count_q <= count_q - 1'b1;
		end
	end

endmodule

// ===== test/host_pin_model.sv
// Host model that drives the two clock-mode pins of the latch sequencer.
`timescale 1ns/10ps
module host_pin_model #(
	parameter int HALF_CYC = 500
) (
	input  wire logic                  clk_sys,
	input  wire logic                  extHigh,
	input  wire logic                  dualHigh,
	input  wire logic                  toggleDual,
	output hall_latch_pkg::clock_pins_t clockPins
);
	int cnt;

	initial begin
		cnt = 0;
		clockPins = '0;
	end

	// The toggled phases of 500 cycles stay above the minimum awake and period.
	always @(negedge clk_sys) begin
		clockPins.extClk <= extHigh;
		if (!toggleDual) begin
			cnt <= 0;
			clockPins.dualClk <= dualHigh;
		end else begin
			cnt <= (cnt + 1) % HALF_CYC;
			if (cnt == 0) begin
				clockPins.dualClk <= ~clockPins.dualClk;
			end
		end
	end
endmodule

// ===== test/test_hall_latch_sample_sequencer.sv
// Self-checking bench of the hall latch sample sequencer.
`timescale 1ns/10ps
`define CHK(act, exp) begin numChecks++; if ((act) !== (exp)) begin nFail++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, (act), (exp)); end end
module test_hall_latch_sample_sequencer;
	logic                         clk_sys;
	logic                         rstn;
	logic                         extHigh;
	logic                         dualHigh;
	logic                         toggleDual;
	hall_latch_pkg::clock_pins_t  clockPins;
	hall_latch_pkg::field_sense_t fieldSense;
	logic                         outLvl;
	logic                         awake;
	logic                         strobe;
	logic                         fast;
	int                           nFail;
	int                           numChecks;
	int                           cycles;

	hall_latch_sample_sequencer #(
		.NORM_PERIOD_CYC(600),
		.SLOW_PERIOD_CYC(1000),
		.TIMEOUT_CYC    (5000)
	) u_dut (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.clockPins    (clockPins),
		.fieldSense   (fieldSense),
		.latchedOutput(outLvl),
		.circuitsAwake(awake),
		.sampleStrobe (strobe),
		.fastSampling (fast)
	);

	host_pin_model #(
		.HALF_CYC(500)
	) u_host (
		.clk_sys   (clk_sys),
		.extHigh   (extHigh),
		.dualHigh  (dualHigh),
		.toggleDual(toggleDual),
		.clockPins (clockPins)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic printVerdict();
		if (nFail == 0 && numChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			nFail++;
			printVerdict();
		end
	end

	task automatic setField(input logic above, input logic below);
		fieldSense.aboveOperateThreshold = above;
		fieldSense.belowReleaseThreshold = below;
	endtask

	task automatic waitAwake(input logic lvl, output int n);
		n = 0;
		while (awake !== lvl && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	task automatic waitStrobe(output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (strobe !== 1'b1 && n < 20000);
	endtask

	task automatic checkNormal();
		int n;
		int a;
		int s;
		setField(1'b1, 1'b0);
		waitStrobe(n);
		`CHK(outLvl, 1'b0)
		waitAwake(1'b0, n);
		waitAwake(1'b1, n);
		waitAwake(1'b0, a);
		`CHK(strobe, 1'b1)
		waitAwake(1'b1, s);
		`CHK(a, 250)
		`CHK(a + s, 600)
		waitStrobe(n);
		setField(1'b0, 1'b1);
		repeat (100) @(negedge clk_sys);
		`CHK(outLvl, 1'b0)
		waitStrobe(n);
		`CHK(outLvl, 1'b1)
		setField(1'b0, 1'b0);
		waitStrobe(n);
		`CHK(outLvl, 1'b1)
	endtask

	task automatic checkExtStatic();
		int n;
		int bad;
		extHigh = 1'b1;
		dualHigh = 1'b1;
		repeat (300) @(negedge clk_sys);
		bad = 0;
		repeat (700) begin
			@(negedge clk_sys);
			if (awake !== 1'b1) bad++;
		end
		`CHK(bad, 0)
		dualHigh = 1'b0;
		waitAwake(1'b0, n);
		`CHK(n >= 250 && n <= 256, 1'b1)
		setField(1'b1, 1'b0);
		bad = 0;
		repeat (700) begin
			@(negedge clk_sys);
			if (awake !== 1'b0 || outLvl !== 1'b1) bad++;
		end
		`CHK(bad, 0)
	endtask

	task automatic checkExtClocked();
		int n;
		int a;
		toggleDual = 1'b1;
		waitAwake(1'b1, n);
		waitAwake(1'b0, a);
		`CHK(a, 500)
		waitStrobe(n);
		`CHK(outLvl, 1'b0)
		toggleDual = 1'b0;
	endtask

	task automatic checkDual();
		int n;
		extHigh = 1'b0;
		dualHigh = 1'b1;
		waitStrobe(n);
		waitStrobe(n);
		`CHK(n, 1000)
		`CHK(fast, 1'b0)
		setField(1'b0, 1'b1);
		waitStrobe(n);
		`CHK(outLvl, 1'b1)
		waitStrobe(n);
		`CHK(fast, 1'b1)
		setField(1'b1, 1'b0);
		waitStrobe(n);
		`CHK(n, 2250)
		`CHK(outLvl, 1'b0)
		setField(1'b0, 1'b0);
		n = 0;
		while (fast !== 1'b0 && n < 8000) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(n >= 4990 && n <= 5005, 1'b1)
	endtask

	initial begin
		nFail = 0;
		numChecks = 0;
		cycles = 0;
		rstn = 1'b0;
		extHigh = 1'b0;
		dualHigh = 1'b0;
		toggleDual = 1'b0;
		setField(1'b0, 1'b0);
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		checkNormal();
		checkExtStatic();
		checkExtClocked();
		checkDual();
		printVerdict();
	end
endmodule
